// File: design/dma_arbiter.sv
// Priority arbiter that picks the most urgent pending channel.
`timescale 1ns/1ps
module dma_arbiter import dma_engine_pkg::*; #(
	parameter int NUM_CH = 32
) (
	input  wire logic [NUM_CH-1:0]   req,
	input  wire logic [2*NUM_CH-1:0] prio,
	output logic                     grantValid,
	output logic [CH_NUM_W-1:0]      grantCh
);

	logic [1:0] best;	// Most urgent priority seen so far.

	// Strict compare keeps the lowest channel number among equal priorities.
	always_comb begin
		grantValid = 1'b0;
		grantCh = '0;
		best = 2'h3;
		for (int i = 0; i < NUM_CH; i++) begin
			if (req[i] && (!grantValid || prio[2*i+:2] < best)) begin
				grantValid = 1'b1;
				grantCh = CH_NUM_W'(i);
				best = prio[2*i+:2];
			end
		end
	end

endmodule

// File: design/dma_engine_status_and_irq.sv
// DMA transfer engine with status, observation and interrupt registers.
`timescale 1ns/1ps
module dma_engine_status_and_irq import dma_engine_pkg::*; #(
	parameter int NUM_CH = 32
) (
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire logic              ce,
	input  wire logic [7:0]        regAddr,
	input  wire logic [31:0]       regWdata,
	input  wire logic              regWr,
	input  wire logic              regRd,
	output logic      [31:0]       regRdata,
	input  wire logic [NUM_CH-1:0] trigIn,
	output logic                   busReq,
	output logic                   busWrite,
	output logic      [31:0]       busAddr,
	output logic      [31:0]       busWdata,
	input  wire logic [31:0]       busRdata,
	input  wire logic              busAck,
	input  wire logic              busErr,
	output logic                   irq
);

	// The channel field is five bits wide, so more channels cannot be named.
	if (NUM_CH < 1 || NUM_CH > MAX_CH) begin : g_bad_num_ch
		$error("NUM_CH must lie between 1 and 32");
	end

	// Whole state of the engine, except the descriptor table, in one record.
	typedef struct packed {
		eng_state_t              st;        // Engine state.
		logic                    engEn;     // Global engine enable.
		logic [NUM_CH-1:0]       chEn;      // Channel enables.
		logic [NUM_CH-1:0]       chLevel;   // Level-sensitive trigger per channel.
		logic [NUM_CH-1:0]       chNext;    // Next descriptor per channel.
		logic [2*NUM_CH-1:0]     prio;      // Two priority bits per channel.
		logic [NUM_CH-1:0]       pend;      // Channels waiting for service.
		logic [NUM_CH-1:0]       trigS1;    // First synchroniser stage.
		logic [NUM_CH-1:0]       trigS2;    // Second synchroniser stage.
		logic [NUM_CH-1:0]       trigPrev;  // Delayed copy for edge detection.
		logic [CH_NUM_W-1:0]     curCh;     // Channel being served.
		logic                    curDesc;   // Descriptor in use.
		logic [1:0]              curPrio;   // Priority of served channel.
		logic [15:0]             idx;       // Element index.
		logic [15:0]             cnt;       // Element count minus one.
		logic [31:0]             srcAddr;   // Live source address.
		logic [31:0]             dstAddr;   // Live destination address.
		logic                    busReq;
		logic                    busWrite;
		logic [31:0]             busAddr;
		logic [31:0]             busWdata;
		logic [1:0]              errLatch;  // Code waiting to be stored.
		logic [2*NUM_CH-1:0]     errCode;   // Per-channel error codes.
		logic [NUM_CH-1:0]       intSrc;    // Sticky interrupt sources.
		logic [NUM_CH-1:0]       intMask;   // Interrupt mask.
		logic                    irq;
		logic [5:0]              descSel;   // Descriptor picked for register access.
		logic [31:0]             rdData;    // Read answer.
	} state_t;

	state_t s_ff;   // Registered state.
	state_t nxt_s;  // Next state.

	// Descriptor table, two entries per channel.
	logic [31:0] descSrcMem [2*NUM_CH];
	logic [31:0] descDstMem [2*NUM_CH];
	logic [15:0] descCntMem [2*NUM_CH];

	logic                grantValid;  // Arbiter found a channel.
	logic [CH_NUM_W-1:0] grantCh;     // Channel chosen by the arbiter.
	logic [5:0]          curIdx;      // Table slot of the running transfer.
	logic [NUM_CH-1:0]   setInt;      // Interrupt events of this cycle.
	logic [NUM_CH-1:0]   newReq;      // New service requests of this cycle.
	logic [NUM_CH-1:0]   grantClr;    // Pending bit taken by the engine.
	logic [NUM_CH-1:0]   activeVec;   // Active or pending channels.
	logic [NUM_CH-1:0]   curOneHot;   // Served channel as a vector.
	logic [31:0]         status;      // Assembled status word.
	logic [2:0]          stateCode;   // Encoded engine state.
	logic [63:0]         prioPad;     // Priorities widened to two words.
	logic                abortNow;    // Running transfer must stop.
	logic                regSlotOk;   // Selected table slot exists.

	assign curIdx = {s_ff.curCh, s_ff.curDesc};
	assign regSlotOk = 32'(s_ff.descSel) < 32'(2 * NUM_CH);

	dma_arbiter #(
		.NUM_CH (NUM_CH)
	) u_arbiter (
		.req        (s_ff.pend & s_ff.chEn),
		.prio       (s_ff.prio),
		.grantValid (grantValid),
		.grantCh    (grantCh)
	);

	// Observation: the status word, the active vector and the state code.
	always_comb begin
		curOneHot = '0;
		if (s_ff.st != ST_IDLE) begin
			curOneHot[s_ff.curCh] = 1'b1;
		end
		activeVec = s_ff.pend | curOneHot;
		case (s_ff.st)
			ST_IDLE:      stateCode = CODE_IDLE;
			ST_DESC_LOAD: stateCode = CODE_DESC_LOAD;
			ST_SRC_READ:  stateCode = CODE_SRC_READ;
			ST_DST_WRITE: stateCode = CODE_DST_WRITE;
			ST_DESC_WB:   stateCode = CODE_DESC_WB;
			ST_WAIT_TRIG: stateCode = CODE_WAIT_TRIG;
			ST_ERROR:     stateCode = CODE_ERROR;
			default:      stateCode = CODE_IDLE;
		endcase
		status = '0;
		status[ST_INDEX_LSB+:16] = (s_ff.st == ST_IDLE) ? 16'h0000 : s_ff.idx;
		status[ST_CHAN_LSB+:CH_NUM_W] = s_ff.curCh;
		status[ST_STATE_LSB+:3] = stateCode;
		status[ST_PRIO_LSB+:2] = s_ff.curPrio;
		status[ST_DESC_BIT] = s_ff.curDesc;
		status[ST_ACTIVE_BIT] = |activeVec;
		prioPad = 64'(s_ff.prio);
	end

	// Next-state logic: engine sequence, then register writes, then flag updates.
	always_comb begin
		nxt_s = s_ff;
		setInt = '0;
		newReq = '0;
		grantClr = '0;
		// Two stages before anything looks at a trigger pin.
		nxt_s.trigS1 = trigIn;
		nxt_s.trigS2 = s_ff.trigS1;
		nxt_s.trigPrev = s_ff.trigS2;
		newReq = s_ff.trigS2 & ~s_ff.trigPrev;
		abortNow = (s_ff.st != ST_IDLE) && (!s_ff.engEn || !s_ff.chEn[s_ff.curCh]);

		case (s_ff.st)
			ST_IDLE: begin
				// New work starts only while the engine is enabled.
				if (s_ff.engEn && grantValid) begin
					nxt_s.st = ST_DESC_LOAD;
					nxt_s.curCh = grantCh;
					nxt_s.curDesc = s_ff.chNext[grantCh];
					nxt_s.curPrio = s_ff.prio[2*grantCh+:2];
					nxt_s.idx = '0;
					grantClr[grantCh] = 1'b1;
				end
			end
			ST_DESC_LOAD: begin
				// Pull the descriptor and launch the first read.
				nxt_s.srcAddr = descSrcMem[curIdx];
				nxt_s.dstAddr = descDstMem[curIdx];
				nxt_s.cnt = descCntMem[curIdx];
				nxt_s.busReq = 1'b1;
				nxt_s.busWrite = 1'b0;
				nxt_s.busAddr = descSrcMem[curIdx];
				nxt_s.st = ST_SRC_READ;
			end
			ST_SRC_READ: begin
				if (busErr) begin
					nxt_s.busReq = 1'b0;
					nxt_s.errLatch = ERR_SRC;
					nxt_s.st = ST_ERROR;
				end else if (busAck) begin
					// Request stays up; the write follows with no idle cycle.
					nxt_s.busWrite = 1'b1;
					nxt_s.busAddr = s_ff.dstAddr;
					nxt_s.busWdata = busRdata;
					nxt_s.st = ST_DST_WRITE;
				end
			end
			ST_DST_WRITE: begin
				if (busErr) begin
					nxt_s.busReq = 1'b0;
					nxt_s.errLatch = ERR_DST;
					nxt_s.st = ST_ERROR;
				end else if (busAck) begin
					nxt_s.srcAddr = s_ff.srcAddr + ADDR_STEP;
					nxt_s.dstAddr = s_ff.dstAddr + ADDR_STEP;
					if (s_ff.idx == s_ff.cnt) begin
						nxt_s.busReq = 1'b0;
						nxt_s.busWrite = 1'b0;
						nxt_s.st = ST_DESC_WB;
					end else begin
						nxt_s.idx = s_ff.idx + 16'h0001;
						nxt_s.busWrite = 1'b0;
						nxt_s.busAddr = s_ff.srcAddr + ADDR_STEP;
						nxt_s.st = ST_SRC_READ;
					end
				end
			end
			ST_DESC_WB: begin
				// Table update happens in the memory process; chain to the other one.
				nxt_s.chNext[s_ff.curCh] = ~s_ff.curDesc;
				setInt[s_ff.curCh] = 1'b1;
				if (s_ff.chLevel[s_ff.curCh] && s_ff.trigS2[s_ff.curCh]) begin
					nxt_s.st = ST_WAIT_TRIG;
				end else begin
					nxt_s.st = ST_IDLE;
				end
			end
			ST_WAIT_TRIG: begin
				// Holding here keeps a still-high level from retriggering.
				if (!s_ff.trigS2[s_ff.curCh]) begin
					nxt_s.st = ST_IDLE;
				end
			end
			ST_ERROR: begin
				nxt_s.errCode[2*s_ff.curCh+:2] = s_ff.errLatch;
				setInt[s_ff.curCh] = 1'b1;
				nxt_s.st = ST_IDLE;
			end
			default: begin
				nxt_s.st = ST_IDLE;
			end
		endcase

		// Losing the channel or engine enable drops the transfer at once.
		if (abortNow) begin
			nxt_s.st = ST_IDLE;
			nxt_s.busReq = 1'b0;
			nxt_s.busWrite = 1'b0;
		end

		// Register writes.
		if (regWr) begin
			case (regAddr)
				OFF_CTRL:     nxt_s.engEn = regWdata[0];
				OFF_INT_MASK: nxt_s.intMask = regWdata[NUM_CH-1:0];
				OFF_CH_EN:    nxt_s.chEn = regWdata[NUM_CH-1:0];
				OFF_CH_LEVEL: nxt_s.chLevel = regWdata[NUM_CH-1:0];
				OFF_SW_TRIG:  newReq = newReq | regWdata[NUM_CH-1:0];
				OFF_CH_NEXT:  nxt_s.chNext = regWdata[NUM_CH-1:0];
				OFF_PRIO_LO: begin
					for (int i = 0; i < NUM_CH && i < 16; i++) begin
						nxt_s.prio[2*i+:2] = regWdata[2*i+:2];
					end
				end
				OFF_PRIO_HI: begin
					for (int i = 16; i < NUM_CH; i++) begin
						nxt_s.prio[2*i+:2] = regWdata[2*(i-16)+:2];
					end
				end
				OFF_DESC_SEL: nxt_s.descSel = regWdata[5:0];
				OFF_CH_ERR: begin
					if (regSlotOk) begin
						nxt_s.errCode[2*s_ff.descSel[5:1]+:2] = ERR_NONE;
					end
				end
				default: begin
					// Other offsets are read-only, table ports, unmapped or OFF_INT_SRC, which is cleared below.
				end
			endcase
		end

		// Pending requests: a new trigger beats the grant clear.
		nxt_s.pend = ((s_ff.pend & ~grantClr) | newReq) & nxt_s.chEn;

		// Interrupt sources: write one clears, a same-cycle event wins.
		nxt_s.intSrc = s_ff.intSrc;
		if (regWr && regAddr == OFF_INT_SRC) begin
			nxt_s.intSrc = s_ff.intSrc & ~regWdata[NUM_CH-1:0];
		end
		nxt_s.intSrc = nxt_s.intSrc | setInt;
		nxt_s.irq = |(nxt_s.intSrc & nxt_s.intMask);

		// Read answer, valid in the cycle after the strobe.
		nxt_s.rdData = '0;
		if (regRd) begin
			case (regAddr)
				OFF_CTRL:       nxt_s.rdData = {31'h0, s_ff.engEn};
				OFF_ACTIVE:     nxt_s.rdData = 32'(activeVec);
				OFF_SRC_ACT:    nxt_s.rdData = s_ff.srcAddr;
				OFF_DST_ACT:    nxt_s.rdData = s_ff.dstAddr;
				OFF_STATUS:     nxt_s.rdData = status;
				OFF_INT_SRC:    nxt_s.rdData = 32'(s_ff.intSrc);
				OFF_INT_MASK:   nxt_s.rdData = 32'(s_ff.intMask);
				OFF_INT_MASKED: nxt_s.rdData = 32'(s_ff.intSrc & s_ff.intMask);
				OFF_CH_EN:      nxt_s.rdData = 32'(s_ff.chEn);
				OFF_CH_LEVEL:   nxt_s.rdData = 32'(s_ff.chLevel);
				OFF_CH_NEXT:    nxt_s.rdData = 32'(s_ff.chNext);
				OFF_PRIO_LO:    nxt_s.rdData = prioPad[31:0];
				OFF_PRIO_HI:    nxt_s.rdData = prioPad[63:32];
				OFF_DESC_SEL:   nxt_s.rdData = {26'h0, s_ff.descSel};
				OFF_DESC_SRC:   nxt_s.rdData = regSlotOk ? descSrcMem[s_ff.descSel] : 32'h0;
				OFF_DESC_DST:   nxt_s.rdData = regSlotOk ? descDstMem[s_ff.descSel] : 32'h0;
				OFF_DESC_CNT:   nxt_s.rdData = regSlotOk ? {16'h0, descCntMem[s_ff.descSel]} : 32'h0;
				OFF_CH_ERR: begin
					if (regSlotOk) begin
						nxt_s.rdData = {30'h0, s_ff.errCode[2*s_ff.descSel[5:1]+:2]};
					end
				end
				default:        nxt_s.rdData = 32'h0;
			endcase
		end
	end

	// State register; clock enable low freezes everything.
	always_ff @(posedge clock) begin
		if (rst) begin
			s_ff <= '0;
			s_ff.st <= ST_IDLE;
			s_ff.engEn <= RST_ENG_EN;
		end else if (ce) begin
			s_ff <= nxt_s;
		end
	end

	// Descriptor table. Write-back blocks any register write to the table in the same cycle, whatever slot it names.
	always_ff @(posedge clock) begin
		if (ce) begin
			if (s_ff.st == ST_DESC_WB) begin
				descSrcMem[curIdx] <= s_ff.srcAddr;
				descDstMem[curIdx] <= s_ff.dstAddr;
			end else if (regWr && regSlotOk) begin
				if (regAddr == OFF_DESC_SRC) begin
					descSrcMem[s_ff.descSel] <= regWdata;
				end
				if (regAddr == OFF_DESC_DST) begin
					descDstMem[s_ff.descSel] <= regWdata;
				end
				if (regAddr == OFF_DESC_CNT) begin
					descCntMem[s_ff.descSel] <= regWdata[15:0];
				end
			end
		end
	end

	assign regRdata = s_ff.rdData;
	assign busReq   = s_ff.busReq;
	assign busWrite = s_ff.busWrite;
	assign busAddr  = s_ff.busAddr;
	assign busWdata = s_ff.busWdata;
	assign irq      = s_ff.irq;

	// Checks on the engine and the interrupt logic.
	sequence srcReadSeq;
		s_ff.st == ST_SRC_READ;
	endsequence

	sequence descLoadSeq;
		ce && s_ff.st == ST_DESC_LOAD && s_ff.engEn && s_ff.chEn[s_ff.curCh];
	endsequence

	irq_follows_a: assert property (@(posedge clock) disable iff (rst)
		ce |=> irq == |($past(nxt_s.intSrc) & $past(nxt_s.intMask)))
		else $error("interrupt output does not follow masked sources");

	clear_exact_a: assert property (@(posedge clock) disable iff (rst)
		ce && regWr && regAddr == OFF_INT_SRC |=>
		((($past(s_ff.intSrc) & ~$past(regWdata[NUM_CH-1:0])) & ~s_ff.intSrc) == '0)
		&& (((s_ff.intSrc & $past(regWdata[NUM_CH-1:0])) & ~$past(setInt)) == '0))
		else $error("interrupt clear hit the wrong bits");

	masked_read_a: assert property (@(posedge clock) disable iff (rst)
		ce && regRd && regAddr == OFF_INT_MASKED |=>
		regRdata == 32'($past(s_ff.intSrc) & $past(s_ff.intMask)))
		else $error("masked source read is wrong");

	state_onehot_a: assert property (@(posedge clock) disable iff (rst)
		$onehot(s_ff.st))
		else $error("engine state is not one-hot");

	load_order_a: assert property (@(posedge clock) disable iff (rst)
		descLoadSeq |=> srcReadSeq ##0 busReq && !busWrite)
		else $error("descriptor load not followed by source read");

	wait_trig_a: assert property (@(posedge clock) disable iff (rst)
		ce && s_ff.st == ST_WAIT_TRIG && s_ff.trigS2[s_ff.curCh] && !abortNow
		|=> s_ff.st == ST_WAIT_TRIG)
		else $error("left trigger wait while trigger high");

	enable_keeps_a: assert property (@(posedge clock) disable iff (rst)
		ce && regWr && regAddr == OFF_CTRL |=> s_ff.chEn == $past(s_ff.chEn))
		else $error("global enable changed channel enables");

	abort_idle_a: assert property (@(posedge clock) disable iff (rst)
		ce && abortNow |=> s_ff.st == ST_IDLE && !busReq)
		else $error("disabled channel transfer not aborted");

	status_active_a: assert property (@(posedge clock) disable iff (rst)
		ce && regRd && regAddr == OFF_STATUS |=>
		regRdata[ST_ACTIVE_BIT] == ($past(|s_ff.pend) || $past(s_ff.st) != ST_IDLE))
		else $error("status active bit is wrong");

	index_bound_a: assert property (@(posedge clock) disable iff (rst)
		s_ff.st == ST_SRC_READ || s_ff.st == ST_DST_WRITE |-> s_ff.idx <= s_ff.cnt)
		else $error("element index ran past the count");

	wb_then_leave_a: assert property (@(posedge clock) disable iff (rst)
		ce && s_ff.st == ST_DST_WRITE && busAck && !busErr && !abortNow
		&& s_ff.idx == s_ff.cnt |=> s_ff.st == ST_DESC_WB ##1 s_ff.st != ST_DESC_WB)
		else $error("write-back state not entered after last element");

endmodule

// File: include/dma_engine_pkg.sv
// Package with the register map, status word layout and state codes of the DMA engine.
// Summary of operation
// - Global enable gates engine; channel enables kept.
// - Readable vector of active or pending channels.
// - Live source and destination addresses readable.
// - Status low half counts element index.
// - Status holds channel, priority, descriptor fields.
// - Status top bit shows active/pending work.
// - Three-bit state field, one state at once.
// - Idle, descriptor load, source read, destination write.
// - Descriptor write-back state after transfer completes.
// - Level trigger waits until trigger goes low.
// - Error state stores channel error code.
// - Interrupt source bit per channel.
// - Written vector clears exactly those source bits.
// - Read/write interrupt mask, same layout.
// - Masked vector equals source AND mask.
// - Four priorities, zero most urgent.
// - Disabling busy channel aborts its transfer.
package dma_engine_pkg;

	// Register byte offsets on the register port.
	localparam logic [7:0] OFF_CTRL       = 8'h00;
	localparam logic [7:0] OFF_ACTIVE     = 8'h04;
	localparam logic [7:0] OFF_SRC_ACT    = 8'h08;
	localparam logic [7:0] OFF_DST_ACT    = 8'h0C;
	localparam logic [7:0] OFF_STATUS     = 8'h10;
	localparam logic [7:0] OFF_INT_SRC    = 8'h14;
	localparam logic [7:0] OFF_INT_MASK   = 8'h18;
	localparam logic [7:0] OFF_INT_MASKED = 8'h1C;
	localparam logic [7:0] OFF_CH_EN      = 8'h20;
	localparam logic [7:0] OFF_CH_LEVEL   = 8'h24;
	localparam logic [7:0] OFF_SW_TRIG    = 8'h28;
	localparam logic [7:0] OFF_CH_NEXT    = 8'h2C;
	localparam logic [7:0] OFF_PRIO_LO    = 8'h30;
	localparam logic [7:0] OFF_PRIO_HI    = 8'h34;
	localparam logic [7:0] OFF_DESC_SEL   = 8'h38;
	localparam logic [7:0] OFF_DESC_SRC   = 8'h3C;
	localparam logic [7:0] OFF_DESC_DST   = 8'h40;
	localparam logic [7:0] OFF_DESC_CNT   = 8'h44;
	localparam logic [7:0] OFF_CH_ERR     = 8'h48;

	// Status word field positions.
	localparam int ST_INDEX_LSB  = 0;
	localparam int ST_CHAN_LSB   = 16;
	localparam int ST_STATE_LSB  = 24;
	localparam int ST_PRIO_LSB   = 28;
	localparam int ST_DESC_BIT   = 30;
	localparam int ST_ACTIVE_BIT = 31;

	// Channel count limits and field widths.
	localparam int MAX_CH   = 32;
	localparam int CH_NUM_W = 5;

	// State codes as seen in the status word.
	localparam logic [2:0] CODE_IDLE      = 3'h0;
	localparam logic [2:0] CODE_DESC_LOAD = 3'h1;
	localparam logic [2:0] CODE_SRC_READ  = 3'h2;
	localparam logic [2:0] CODE_DST_WRITE = 3'h3;
	localparam logic [2:0] CODE_DESC_WB   = 3'h4;
	localparam logic [2:0] CODE_WAIT_TRIG = 3'h5;
	localparam logic [2:0] CODE_ERROR     = 3'h6;

	// Channel error codes.
	localparam logic [1:0] ERR_NONE = 2'h0;
	localparam logic [1:0] ERR_SRC  = 2'h1;
	localparam logic [1:0] ERR_DST  = 2'h2;

	// Values after reset and address step per word element.
	localparam logic        RST_ENG_EN = 1'b0;
	localparam logic [31:0] ADDR_STEP  = 32'h0000_0004;

	// One-hot engine states.
	typedef enum logic [6:0] {
		ST_IDLE      = 7'h01,
		ST_DESC_LOAD = 7'h02,
		ST_SRC_READ  = 7'h04,
		ST_DST_WRITE = 7'h08,
		ST_DESC_WB   = 7'h10,
		ST_WAIT_TRIG = 7'h20,
		ST_ERROR     = 7'h40
	} eng_state_t;

endpackage

// File: testbench/mem_partner.sv
// Memory-side model that answers the engine's bus accesses after a set delay.
`timescale 1ns/1ps
module mem_partner (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        busReq,
	input  wire logic        busWrite,
	input  wire logic [31:0] busAddr,
	input  wire logic [31:0] busWdata,
	input  wire logic [7:0]  ackDelay,
	input  wire logic        errNext,
	output logic      [31:0] busRdata,
	output logic             busAck,
	output logic             busErr,
	output logic      [31:0] lastWdata
);
	logic [7:0] waitCnt_ff; // Cycles the current access has waited.
	logic       resp_ff;    // High in the one cycle that answers.

	// Count while a request stands, answer once, then start over for the next access.
	always_ff @(posedge clock) begin
		if (rst || !busReq || resp_ff) begin
			waitCnt_ff <= 8'h00;
			resp_ff <= 1'b0;
		end else if (waitCnt_ff == ackDelay) begin
			resp_ff <= 1'b1;
		end else begin
			waitCnt_ff <= waitCnt_ff + 8'h01;
		end
	end

	// Answer only while the request is still up, so an aborted access is never acknowledged.
	assign busAck = resp_ff && busReq && !errNext;
	assign busErr = resp_ff && busReq && errNext;
	// Read data are valid only in the answer cycle; elsewhere the lines carry the inverse.
	assign busRdata = resp_ff ? (busAddr ^ 32'hA5A5_0000) : ~(busAddr ^ 32'hA5A5_0000);

	// Keep the last written word so the bench can compare what arrived.
	always_ff @(posedge clock) begin
		if (busAck && busWrite) begin
			lastWdata <= busWdata;
		end
	end
endmodule

// File: testbench/testbench.sv
// Self-checking bench for the DMA engine status and interrupt registers.
`timescale 1ns/1ps
module testbench import dma_engine_pkg::*;;
	logic        clock, rst, ce, regWr, regRd, irq;
	logic [7:0]  regAddr, ackDelay;
	logic [31:0] regWdata, regRdata, rd, lastWdata;
	logic        busReq, busWrite, busAck, busErr, errNext;
	logic [31:0] busAddr, busWdata, busRdata;
	logic [31:0] trigIn;
	int          failures, samples_checked, i;

	dma_engine_status_and_irq #(.NUM_CH(32)) u_dma_engine_status_and_irq (
		.clock(clock), .rst(rst), .ce(ce), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .trigIn(trigIn),
		.busReq(busReq), .busWrite(busWrite), .busAddr(busAddr), .busWdata(busWdata),
		.busRdata(busRdata), .busAck(busAck), .busErr(busErr), .irq(irq));
	mem_partner u_mem_partner (
		.clock(clock), .rst(rst), .busReq(busReq), .busWrite(busWrite), .busAddr(busAddr),
		.busWdata(busWdata), .ackDelay(ackDelay), .errNext(errNext), .busRdata(busRdata),
		.busAck(busAck), .busErr(busErr), .lastWdata(lastWdata));

	// Free-running 250 MHz clock.
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// One register write: a single strobe cycle.
	task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clock);
		regWr <= 1'b0;
	endtask

	// One register read: data stand only in the cycle after the strobe.
	task automatic regRead(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clock);
		regRd <= 1'b0;
		#1 d = regRdata;
	endtask

	// Compare one value and count it.
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
			failures++;
		end
	endtask

	// Read a register and compare it in one step.
	task automatic readCheck(input string name, input logic [7:0] a, input logic [31:0] exp);
		regRead(a, rd);
		check(name, exp, rd);
	endtask

	// Single place where the run ends.
	task automatic report_and_stop();
		if (failures == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Wait a bounded time for the engine to raise a bus request of the given direction.
	task automatic waitBus(input logic wr);
		for (i = 0; i < 300 && !(busReq && busWrite == wr); i++) @(posedge clock);
		#1;
	endtask

	// A hang counts as a mismatch; the tests need well under a thousand cycles.
	initial begin
		#40000;
		failures++;
		report_and_stop();
	end

	// Main test sequence.
	initial begin
		{rst, ce, regWr, regRd, errNext} = 5'b11000;
		{regAddr, regWdata, trigIn} = '0;
		ackDelay = 8'h0C;
		failures = 0;
		samples_checked = 0;
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		readCheck("ctrl reset", OFF_CTRL, 32'h0000_0000);
		readCheck("status idle", OFF_STATUS, 32'h0000_0000);
		readCheck("unmapped", 8'h4C, 32'h0000_0000);
		regWrite(OFF_INT_MASK, 32'h0000_0001);
		readCheck("mask", OFF_INT_MASK, 32'h0000_0001);
		// Two word elements from 0x100 to 0x200 on channel 0, descriptor 0.
		regWrite(OFF_DESC_SEL, 32'h0000_0000);
		regWrite(OFF_DESC_SRC, 32'h0000_0100);
		regWrite(OFF_DESC_DST, 32'h0000_0200);
		regWrite(OFF_DESC_CNT, 32'h0000_0001);
		regWrite(OFF_CH_EN, 32'h0000_0001);
		regWrite(OFF_CTRL, 32'h0000_0001);
		regWrite(OFF_SW_TRIG, 32'h0000_0001);
		waitBus(1'b0);
		readCheck("status read", OFF_STATUS, {5'b10000, CODE_SRC_READ, 24'h0});
		readCheck("active vec", OFF_ACTIVE, 32'h0000_0001);
		readCheck("live src", OFF_SRC_ACT, 32'h0000_0100);
		for (i = 0; i < 300 && !(busReq && busAddr == 32'h0000_0204); i++) @(posedge clock);
		readCheck("status write", OFF_STATUS, {5'b10000, CODE_DST_WRITE, 24'h1});
		readCheck("live dst", OFF_DST_ACT, 32'h0000_0204);
		for (i = 0; i < 300 && irq !== 1'b1; i++) @(posedge clock);
		check("irq set", 32'h1, {31'h0, irq});
		check("moved data", 32'hA5A5_0104, lastWdata);
		readCheck("int src", OFF_INT_SRC, 32'h0000_0001);
		readCheck("masked", OFF_INT_MASKED, 32'h0000_0001);
		readCheck("next desc", OFF_CH_NEXT, 32'h0000_0001);
		readCheck("idle again", OFF_STATUS, 32'h0000_0000);
		regWrite(OFF_INT_SRC, 32'h0000_0002);
		readCheck("clear other", OFF_INT_SRC, 32'h0000_0001);
		regWrite(OFF_INT_SRC, 32'h0000_0001);
		readCheck("clear own", OFF_INT_SRC, 32'h0000_0000);
		check("irq clear", 32'h0, {31'h0, irq});
		// A failing source read with the interrupt masked off.
		regWrite(OFF_INT_MASK, 32'h0000_0000);
		regWrite(OFF_CH_NEXT, 32'h0000_0000);
		errNext <= 1'b1;
		regWrite(OFF_SW_TRIG, 32'h0000_0001);
		for (i = 0; i < 300 && busErr !== 1'b1; i++) @(posedge clock);
		repeat (4) @(posedge clock);
		errNext <= 1'b0;
		readCheck("err code", OFF_CH_ERR, {30'h0, ERR_SRC});
		readCheck("err src", OFF_INT_SRC, 32'h0000_0001);
		readCheck("err masked", OFF_INT_MASKED, 32'h0000_0000);
		check("irq masked", 32'h0, {31'h0, irq});
		// Stopping the engine leaves channel enables alone.
		regWrite(OFF_CTRL, 32'h0000_0000);
		readCheck("ch en kept", OFF_CH_EN, 32'h0000_0001);
		regWrite(OFF_CTRL, 32'h0000_0001);
		// Disabling the channel mid-access aborts the transfer.
		ackDelay <= 8'h60;
		regWrite(OFF_SW_TRIG, 32'h0000_0001);
		waitBus(1'b0);
		regWrite(OFF_CH_EN, 32'h0000_0000);
		repeat (2) @(posedge clock);
		#1;
		check("abort req", 32'h0, {31'h0, busReq});
		regRead(OFF_STATUS, rd);
		check("abort idle", 32'h0, rd & 32'h8700_0000);
		// A level trigger on the pin: the engine waits until the pin goes low again.
		ackDelay <= 8'h02;
		regWrite(OFF_CH_LEVEL, 32'h0000_0001);
		regWrite(OFF_CH_EN, 32'h0000_0001);
		trigIn <= 32'h0000_0001;
		repeat (60) @(posedge clock);
		readCheck("wait trig", OFF_STATUS, 32'h8500_0001);
		trigIn <= 32'h0000_0000;
		repeat (6) @(posedge clock);
		readCheck("trig low", OFF_STATUS, 32'h0000_0000);
		report_and_stop();
	end
endmodule
